// ==== verilog/kbd_regs.svh ====
// register offsets, field positions and reset values of the keyboard unit
// assumes inclusion by the modules and the bench that need the map
`ifndef KBD_REGS_SVH
`define KBD_REGS_SVH

`define KBD_STATUS_CONTROL_OFF 4'h0
`define KBD_PIN_ENABLE_OFF     4'h4
`define KBD_IRQ_STATUS_OFF     4'h8
`define KBD_IRQ_MASK_OFF       4'hc

`define KBD_SENS_BIT    0
`define KBD_MASK_BIT    1
`define KBD_ACK_BIT     2
`define KBD_PEND_BIT    3

`define KBD_SC_RESET    8'h00
`define KBD_PE_RESET    8'h00
`define KBD_IM_RESET    8'h00

`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ==== verilog/kbd_pkg.sv ====
// types shared by the keyboard interrupt unit
// assumes nothing beyond a SystemVerilog compiler
package kbd_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  addr_t;
  typedef enum logic [1:0]
  {
    bus_idle = 2'b00,
    bus_resp = 2'b01
  } bus_state_e;
endpackage

// ==== verilog/kbd_pin_detect.sv ====
// per-pin synchroniser and shared request latch of the keyboard unit
// assumes raw port pins from outside the clock domain
`timescale 1ns/1ps
module kbd_pin_detect
#(
  parameter int PINS = 8
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [PINS-1:0] pin_raw,
  input  wire logic [PINS-1:0] pin_request_enable_bits,
  input  wire logic            kbd_sensitivity_select,
  input  wire logic            ack_pulse,
  output logic                 kbd_pending_flag
);
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic            any_low;
  logic            any_low_q;
  logic            latch;
  logic            ack_seen;

  // two stages before detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= '1;
      sync_b <= '1;
    end
    else
    begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  assign any_low = |(~sync_b & pin_request_enable_bits);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      any_low_q <= 1'b0;
    else
      any_low_q <= any_low;
  end

  // set on all-high to any-low; set wins over acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch    <= 1'b0;
      ack_seen <= 1'b0;
    end
    else if (any_low && !any_low_q)
    begin
      latch    <= 1'b1;
      ack_seen <= 1'b0;
    end
    else if (!kbd_sensitivity_select)
    begin
      ack_seen <= 1'b0;
      if (ack_pulse)
        latch <= 1'b0;
    end
    else
    begin
      if (ack_pulse && !any_low)
        latch <= 1'b0;
      else if (ack_seen && !any_low)
        latch <= 1'b0;
      if (ack_pulse && any_low)
        ack_seen <= latch;
      else if (!any_low)
        ack_seen <= 1'b0;
    end
  end

  assign kbd_pending_flag = latch;
endmodule

// ==== verilog/keyboard_interrupt_ctrl.sv ====
// Function
// - unit stays active in wait; unmasked request raises wake request.
// - unit stays active in stop; unmasked request raises wake request.
// - with break clear enabled, acknowledge in break clears the latch.
// - with break clear disabled, acknowledge in break does nothing.
// - upper four status/control bits read zero.
// - pending flag reads latch state; reset clears it.
// - writing one to acknowledge clears request; reads zero.
// - mask bit blocks request output; reset clears it.
// - sensitivity bit selects edge-plus-level or edge-only.
// - each enable bit lets its pin latch requests; reset clears.
// - request latches when enabled pins go low after all high.
// - level mode needs acknowledge and pins high; edge mode acknowledge.
// - enabled pin forced to input with pullup on.
// - eight inputs share one mask and request; flag ignores mask.
// keyboard interrupt unit with AXI4-Lite registers
// assumes one clock, synchronous active-low reset, pins outside domain
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "kbd_regs.svh"
module keyboard_interrupt_ctrl
#(
  parameter int PINS = 8
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire kbd_pkg::addr_t  s_axi_awaddr,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  input  wire kbd_pkg::word_t  s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  output logic [1:0]           s_axi_bresp,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  input  wire kbd_pkg::addr_t  s_axi_araddr,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output kbd_pkg::word_t       s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  input  wire logic [PINS-1:0] port_a_pin,
  input  wire logic [PINS-1:0] port_a_direction_bits,
  input  wire logic            break_state,
  input  wire logic            break_clear_enable,
  output logic [PINS-1:0]      port_a_dir_eff,
  output logic [PINS-1:0]      port_a_pullup,
  output logic                 kbd_irq_request,
  output logic                 kbd_wake,
  output logic                 irq
);
  import kbd_pkg::*;

  logic            kbd_request_mask;
  logic            kbd_sensitivity_select;
  logic [PINS-1:0] pin_request_enable_bits;
  logic            kbd_pending_flag;
  logic            ack_pulse;
  logic            pend_q;
  logic [1:0]      irq_status;
  logic [1:0]      irq_mask;
  logic            aw_held;
  logic            w_held;
  addr_t           aw_addr;
  word_t           w_data;
  logic [3:0]      w_strb;
  logic            do_write;
  bus_state_e      rd_state;

  // reset values cut to byte width
  localparam byte_t sc_reset = `KBD_SC_RESET;
  localparam byte_t pe_reset = `KBD_PE_RESET;
  localparam byte_t im_reset = `KBD_IM_RESET;

  function automatic logic is_mapped(input addr_t a);
    if (a == `KBD_STATUS_CONTROL_OFF)
      is_mapped = 1'b1;
    else if (a == `KBD_PIN_ENABLE_OFF)
      is_mapped = 1'b1;
    else if (a == `KBD_IRQ_STATUS_OFF)
      is_mapped = 1'b1;
    else if (a == `KBD_IRQ_MASK_OFF)
      is_mapped = 1'b1;
    else
      is_mapped = 1'b0;
  endfunction

  kbd_pin_detect
  #(
    .PINS(PINS)
  )
  u_detect
  (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .pin_raw                 (port_a_pin),
    .pin_request_enable_bits (pin_request_enable_bits),
    .kbd_sensitivity_select  (kbd_sensitivity_select),
    .ack_pulse               (ack_pulse),
    .kbd_pending_flag        (kbd_pending_flag)
  );

  // write channel capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? `AXI_RESP_OKAY
                                         : `AXI_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control register fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kbd_request_mask        <= sc_reset[`KBD_MASK_BIT];
      kbd_sensitivity_select  <= sc_reset[`KBD_SENS_BIT];
      pin_request_enable_bits <= pe_reset[PINS-1:0];
      irq_mask                <= im_reset[1:0];
    end
    else if (do_write && w_strb[0])
    begin
      if (aw_addr == `KBD_STATUS_CONTROL_OFF)
      begin
        kbd_request_mask       <= w_data[`KBD_MASK_BIT];
        kbd_sensitivity_select <= w_data[`KBD_SENS_BIT];
      end
      else if (aw_addr == `KBD_PIN_ENABLE_OFF)
        pin_request_enable_bits <= w_data[PINS-1:0];
      else if (aw_addr == `KBD_IRQ_MASK_OFF)
        irq_mask <= w_data[1:0];
    end
  end

  // acknowledge pulse, gated in break unless clear enabled
  always_comb
  begin
    ack_pulse = do_write && w_strb[0]
                && aw_addr == `KBD_STATUS_CONTROL_OFF
                && w_data[`KBD_ACK_BIT]
                && (!break_state || break_clear_enable);
  end

  // sticky events: bit0 request latched, bit1 request cleared
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q     <= 1'b0;
      irq_status <= 2'b00;
    end
    else
    begin
      pend_q <= kbd_pending_flag;
      for (int i = 0; i < 2; i++)
      begin
        if ((i == 0) ? (kbd_pending_flag && !pend_q)
                     : (!kbd_pending_flag && pend_q))
          irq_status[i] <= 1'b1;
        else if (do_write && w_strb[0] && aw_addr == `KBD_IRQ_STATUS_OFF
                 && w_data[i])
          irq_status[i] <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state      <= bus_idle;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        bus_idle:
        begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready)
          begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            rd_state      <= bus_resp;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? `AXI_RESP_OKAY
                                                     : `AXI_RESP_SLVERR;
            if (s_axi_araddr == `KBD_STATUS_CONTROL_OFF)
              s_axi_rdata <= {28'h0000000,
                              kbd_pending_flag, 1'b0,
                              kbd_request_mask, kbd_sensitivity_select};
            else if (s_axi_araddr == `KBD_PIN_ENABLE_OFF)
              s_axi_rdata <= {{(32-PINS){1'b0}}, pin_request_enable_bits};
            else if (s_axi_araddr == `KBD_IRQ_STATUS_OFF)
              s_axi_rdata <= {30'h00000000, irq_status};
            else if (s_axi_araddr == `KBD_IRQ_MASK_OFF)
              s_axi_rdata <= {30'h00000000, irq_mask};
            else
              s_axi_rdata <= '0;
          end
        end
        bus_resp:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= bus_idle;
          end
        end
        default:
          rd_state <= bus_idle;
      endcase
    end
  end

  // pin direction override, request and interrupt outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_a_dir_eff  <= '0;
      port_a_pullup   <= '0;
      kbd_irq_request <= 1'b0;
      kbd_wake        <= 1'b0;
      irq             <= 1'b0;
    end
    else
    begin
      port_a_dir_eff  <= port_a_direction_bits
                         & ~pin_request_enable_bits;
      port_a_pullup   <= pin_request_enable_bits;
      kbd_irq_request <= kbd_pending_flag && !kbd_request_mask;
      kbd_wake        <= kbd_pending_flag && !kbd_request_mask;
      irq             <= |(irq_status & ~irq_mask);
    end
  end
endmodule

// ==== verif/keyboard_interrupt_ctrl_sva.sv ====
// concurrent checks on the keyboard unit ports
// assumes binding onto keyboard_interrupt_ctrl, one clock
`timescale 1ns/1ps
`include "kbd_regs.svh"
module kbd_checker
#(
  parameter int PINS = 8
)
(
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire kbd_pkg::addr_t s_axi_araddr,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready,
  input wire kbd_pkg::word_t s_axi_rdata,
  input wire logic [1:0]     s_axi_rresp,
  input wire logic [PINS-1:0] port_a_dir_eff,
  input wire logic [PINS-1:0] port_a_pullup,
  input wire logic           kbd_irq_request,
  input wire logic           kbd_wake,
  input wire logic           irq
);
  import kbd_pkg::*;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  addr_t ra;
  // address of the read under way
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      ra <= s_axi_araddr;
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_unmapped_read: assert property (s_axi_rvalid && ra[1:0] != 2'h0
    |-> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  a_status_zeros: assert property (
    s_axi_rvalid && ra == `KBD_STATUS_CONTROL_OFF
    |-> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[`KBD_ACK_BIT])
    else $error("status upper or ack bit set");
  a_wake_request: assert property (
    kbd_wake == kbd_irq_request)
    else $error("wake differs from request");
  a_pin_forced_in: assert property (
    (port_a_pullup & port_a_dir_eff) == '0)
    else $error("enabled pin not input");
  a_reset_clears: assert property (disable iff (1'b0)
    !aresetn |=> !kbd_irq_request && !irq && port_a_pullup == '0)
    else $error("reset left outputs set");
endmodule
bind keyboard_interrupt_ctrl kbd_checker #(.PINS(PINS)) i_kbd_checker (.*);

// ==== verif/keypad_model.sv ====
// keypad on the port pins: a pressed key pulls its line low
// assumes pullup enables from the unit, presses from the bench
`timescale 1ns/1ps
module keypad_model
(
  input  wire logic       aclk,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] driven_high,
  input  wire logic [7:0] press,
  output logic [7:0]      pins
);
  logic [7:0] charged = 8'h00;
  logic [7:0] noise = 8'h55;
  // pullup takes a cycle to charge the line; a driven line is charged
  always @(posedge aclk)
  begin
    charged <= pullup_on | driven_high;
    noise <= ~noise;
  end
  // a line without pullup or drive floats
  assign pins = ~press & (charged | driven_high
                | (~pullup_on & ~driven_high & noise));
endmodule

// ==== verif/tb.sv ====
// register-level tests of the keyboard unit
// assumes the unit, its checker and the keypad model
`timescale 1ns/1ps
`include "kbd_regs.svh"
module tb;
  import kbd_pkg::*;
  localparam addr_t SC = `KBD_STATUS_CONTROL_OFF;
  localparam addr_t PE = `KBD_PIN_ENABLE_OFF;
  localparam addr_t IS = `KBD_IRQ_STATUS_OFF;
  localparam addr_t IM = `KBD_IRQ_MASK_OFF;
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
  word_t s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, kbd_irq_request, kbd_wake, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] port_a_pin, port_a_dir_eff, port_a_pullup, press = '0;
  logic [7:0] port_a_direction_bits = 8'hf0;
  logic break_state = 0, break_clear_enable = 0;
  int n_errors = 0, n_compared = 0;
  always #2.5 aclk = ~aclk;
  keyboard_interrupt_ctrl i_keyboard_interrupt_ctrl (.*);
  keypad_model i_keypad_model (.aclk(aclk), .pullup_on(port_a_pullup),
    .driven_high(port_a_dir_eff), .press(press), .pins(port_a_pin));
  task complete_run;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, got);
    end
  endtask
  task wr(input addr_t a, input word_t d, input logic [3:0] s = 4'h1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input addr_t a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rchk(input addr_t a, input word_t e);
    rd(a);
    chk($sformatf("reg %h", a), rdat, e);
  endtask
  task settle;
    repeat (8) @(posedge aclk);
  endtask
  initial
  begin
    #50000;
    n_errors++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(SC, 32'h0);
    rchk(PE, 32'h0);
    rchk(IM, 32'h0);
    rd(4'h2);
    chk("rresp", resp, `AXI_RESP_SLVERR);
    wr(4'h6, 32'h0);
    chk("bresp", resp, `AXI_RESP_SLVERR);
    wr(PE, 32'hff, 4'h0);
    rchk(PE, 32'h0);
    // masked start-up
    wr(SC, 32'h02);
    wr(PE, 32'h0f);
    settle;
    rchk(SC, 32'h0a);
    chk("pullup", port_a_pullup, 8'h0f);
    chk("dir", port_a_dir_eff, 8'hf0);
    wr(SC, 32'h06);
    wr(SC, 32'h00);
    rchk(SC, 32'h0);
    rchk(PE, 32'h0f);
    // pin already driven high before it is enabled
    wr(PE, 32'h1f);
    settle;
    rchk(SC, 32'h0);
    chk("pullup", port_a_pullup, 8'h1f);
    chk("dir", port_a_dir_eff, 8'he0);
    // edge only
    press <= 8'h01;
    settle;
    rchk(SC, 32'h08);
    chk("request", kbd_irq_request, 1'b1);
    wr(SC, 32'h04);
    rchk(SC, 32'h0);
    press <= 8'h03;
    settle;
    rchk(SC, 32'h0);
    press <= 8'h20;
    settle;
    rchk(SC, 32'h0);
    // masked request
    wr(SC, 32'h02);
    press <= 8'h04;
    settle;
    rchk(SC, 32'h0a);
    chk("request", kbd_irq_request, 1'b0);
    chk("wake", kbd_wake, 1'b0);
    wr(SC, 32'h00);
    settle;
    chk("request", kbd_irq_request, 1'b1);
    chk("wake", kbd_wake, 1'b1);
    wr(SC, 32'h04);
    press <= 8'h00;
    settle;
    rchk(SC, 32'h0);
    // edge and level
    wr(SC, 32'h01);
    press <= 8'h08;
    settle;
    rchk(SC, 32'h09);
    wr(SC, 32'h05);
    rchk(SC, 32'h09);
    press <= 8'h00;
    settle;
    rchk(SC, 32'h01);
    // break state
    wr(SC, 32'h00);
    break_state <= 1'b1;
    press <= 8'h02;
    settle;
    wr(SC, 32'h04);
    rchk(SC, 32'h08);
    break_clear_enable <= 1'b1;
    wr(SC, 32'h04);
    break_state <= 1'b0;
    settle;
    rchk(SC, 32'h0);
    press <= 8'h00;
    break_clear_enable <= 1'b0;
    // sticky status, mask, clear
    settle;
    chk("irq", irq, 1'b1);
    rchk(IS, 32'h03);
    wr(IM, 32'h03);
    settle;
    chk("irq", irq, 1'b0);
    rchk(IM, 32'h03);
    wr(IS, 32'h03);
    rchk(IS, 32'h0);
    wr(IM, 32'h00);
    press <= 8'h01;
    settle;
    chk("irq", irq, 1'b1);
    rchk(IS, 32'h01);
    complete_run;
  end
endmodule
